// File: hdlcf_pkg.sv
package hdlcf_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TXDATA = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IMASK = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h14;
  localparam logic [7:0] OFS_TRIG = 8'h18;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_TXQ_EN = 0;
  localparam int CTRL_CRC32 = 1;
  localparam int CTRL_SEND_ONES = 2;
  localparam int ST_OVERRUN = 3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] IMASK_RST = 4'h0;
  localparam logic [4:0] TRIG_RST = 5'h01;
  // ----------------------------------------
  // line patterns and check constants
  // ----------------------------------------
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] ABORT_BYTE = 8'hFF;
  localparam logic [3:0] STUFF_RUN = 4'h5;
  localparam logic [3:0] ABORT_RUN = 4'h7;
  localparam logic [3:0] HALF_LEVEL = 4'h4;
  localparam logic [31:0] POLY16 = 32'h00001021;
  localparam logic [31:0] POLY32 = 32'h04C11DB7;
  localparam logic [31:0] RES16 = 32'h00001D0F;
  localparam logic [31:0] RES32 = 32'hC704DD7B;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic abort_detected;
    logic crc_error;
    logic flag_detected;
    logic [7:0] data;
  } hdlcf_rxent_s;
  typedef enum logic [1:0] {TX_FLAG, TX_DATA, TX_FCS, TX_ONES} hdlcf_tx_e;
  typedef enum logic {RX_HUNT, RX_DATA} hdlcf_rx_e;
endpackage

// File: hdlcf_fifo.sv
`timescale 1ns/1ns
module hdlcf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic full,
  output logic empty,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  logic [W-1:0] mem [DEPTH];  // entries, no reset needed
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("depth must be a power of two");
  end

  // push into a full queue is dropped, pop from empty ignored
  always_comb begin
    do_push = push && !full;
    do_pop = pop && !empty;
    wp_d = do_push ? wp_q + 1'b1 : wp_q;
    rp_d = do_pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end

  // pointer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // data array write
  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wp_q] <= wdata;
    end
  end

  assign rdata = mem[rp_q];
  assign full = cnt_q == DEPTH[AW:0];
  assign empty = cnt_q == '0;
  assign count = cnt_q;
endmodule

// File: hdlcf_top.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Overview of operation
// - flags are 7E, opening and closing
// - shared flag and zero-shared flags accepted
// - fields handled as plain byte stream
// - transmit stuffs zero after five ones
// - no stuffing while sending flags
// - receiver drops zero after five ones
// - seven unstuffed ones abort frame at once
// - seven or more ones abort, fifteen plus treated alike
// - idle line filled with back-to-back flags
// - CRC16 default, CRC32 selectable, flags excluded
// - preset ones, send complement, MSB first
// - 16-byte queues, transmit queue needs enable
// - half-full at four, not-full, not-empty
// - status changes raise masked interrupt
// - receive entry: byte plus three flags
// - overrun immediate, bytes dropped while full
// - first flag stores 7E with status
// - following flags in run not stored
// - eight zeros stored, error on next flag
// - abort stores FFh with only abort set
// - data ready at trigger level, default one
module hdlcf_top
  import hdlcf_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int BIT_DIV = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic line_txd,
  input wire logic line_rxd,
  input wire logic line_rx_clk,
  output logic status_irq
);
  import hdlcf_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;

  if (DEPTH < 4 || BIT_DIV < 2) begin : g_chk
    $error("depth below half-full level or divider too small");
  end

  // ----------------------------------------
  // crc helpers, msb-first shift
  // ----------------------------------------
  function automatic logic [31:0] crc_bit(logic [31:0] c, logic b, logic wide);
    logic fb;
    fb = (wide ? c[31] : c[15]) ^ b;
    crc_bit = (c << 1) ^ (fb ? (wide ? POLY32 : POLY16) : 32'h0);
    if (!wide) begin
      crc_bit[31:16] = 16'h0;
    end
  endfunction

  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] d, logic wide);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = crc_bit(r, d[i], wide);
    end
    crc_byte = r;
  endfunction

  // ----------------------------------------
  // registers and status
  // ----------------------------------------
  logic [2:0] ctrl_q, ctrl_d;     // queue enable, crc32, send ones
  logic [3:0] imask_q, imask_d;   // new_status_irq_enable bits
  logic [3:0] ists_q, ists_d;     // sticky change flags
  logic [3:0] stat_prev_q;        // last seen queue status
  logic [4:0] trig_q, trig_d;     // receive trigger level
  logic ovr_q, ovr_d;             // receive overrun
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_go, rd_go;             // accepted accesses
  logic tx_push, rx_pop;
  logic [3:0] stat_now;           // tx_hf, rx_hf, tx_nf, rx_ne
  logic tx_queue_half_full, rx_queue_half_full;
  logic tx_queue_not_full, rx_queue_not_empty, rx_data_ready;

  // ----------------------------------------
  // queues
  // ----------------------------------------
  logic [7:0] txq_rdata;
  logic txq_full, txq_empty, txq_pop;
  logic [CW-1:0] txq_cnt, rxq_cnt;
  hdlcf_rxent_s rxq_wdata, rxq_rdata;
  logic rxq_push, rxq_full, rxq_empty;

  hdlcf_fifo #(.W(8), .DEPTH(DEPTH)) u_txq (
    .aclk(aclk), .aresetn(aresetn), .push(tx_push), .wdata(s_axi_wdata[7:0]),
    .pop(txq_pop), .rdata(txq_rdata), .full(txq_full), .empty(txq_empty),
    .count(txq_cnt)
  );
  // entry keeps byte and its three flags
  hdlcf_fifo #(.W($bits(hdlcf_rxent_s)), .DEPTH(DEPTH)) u_rxq (
    .aclk(aclk), .aresetn(aresetn), .push(rxq_push), .wdata(rxq_wdata),
    .pop(rx_pop), .rdata(rxq_rdata), .full(rxq_full), .empty(rxq_empty),
    .count(rxq_cnt)
  );

  // queue status; without enable the transmit side holds one byte
  always_comb begin
    tx_queue_half_full = txq_cnt >= CW'(HALF_LEVEL);
    rx_queue_half_full = rxq_cnt >= CW'(HALF_LEVEL);
    tx_queue_not_full = ctrl_q[CTRL_TXQ_EN] ? !txq_full : txq_empty;
    rx_queue_not_empty = !rxq_empty;
    rx_data_ready = !rxq_empty && (rxq_cnt >= CW'(trig_q));
    stat_now = {tx_queue_half_full, rx_queue_half_full, tx_queue_not_full,
      rx_queue_not_empty};
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  // write taken only with address and data both present
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !rvalid_q;
  assign wr_go = s_axi_awready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign tx_push = wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFS_TXDATA
    && tx_queue_not_full;
  // data read advances the queue, so status must be read first
  assign rx_pop = rd_go && s_axi_araddr == OFS_RXDATA;

  // register writes, reads and answers
  always_comb begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    trig_d = trig_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    ovr_d = ovr_q;
    // change of any queue status sets its sticky bit
    ists_d = ists_q;
    if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFS_ISTAT) begin
      ists_d = ists_q & ~s_axi_wdata[3:0];
    end
    ists_d = ists_d | (stat_now ^ stat_prev_q);
    // host clears overrun, a new overrun wins
    if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFS_STATUS
        && s_axi_wdata[ST_OVERRUN]) begin
      ovr_d = 1'b0;
    end
    if (rxq_push && rxq_full) begin
      ovr_d = 1'b1;
    end
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (s_axi_awaddr == OFS_CTRL) begin
        if (s_axi_wstrb[0]) ctrl_d = s_axi_wdata[2:0];
      end else if (s_axi_awaddr == OFS_IMASK) begin
        if (s_axi_wstrb[0]) imask_d = s_axi_wdata[3:0];
      end else if (s_axi_awaddr == OFS_TRIG) begin
        if (s_axi_wstrb[0]) trig_d = s_axi_wdata[4:0];
      end else if (s_axi_awaddr == OFS_TXDATA || s_axi_awaddr == OFS_STATUS
          || s_axi_awaddr == OFS_ISTAT) begin
        bresp_d = RESP_OKAY;
      end else begin
        bresp_d = RESP_SLVERR; // unmapped
      end
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0;
      if (s_axi_araddr == OFS_CTRL) begin
        rdata_d[2:0] = ctrl_q;
      end else if (s_axi_araddr == OFS_RXDATA) begin
        rdata_d[7:0] = rxq_rdata.data;
      end else if (s_axi_araddr == OFS_STATUS) begin
        rdata_d[8:0] = {stat_now, rx_data_ready, ovr_q, rxq_rdata.flag_detected,
          rxq_rdata.crc_error, rxq_rdata.abort_detected};
      end else if (s_axi_araddr == OFS_IMASK) begin
        rdata_d[3:0] = imask_q;
      end else if (s_axi_araddr == OFS_ISTAT) begin
        rdata_d[3:0] = ists_q;
      end else if (s_axi_araddr == OFS_TRIG) begin
        rdata_d[4:0] = trig_q;
      end else begin
        rresp_d = RESP_SLVERR; // unmapped reads zero
      end
    end
  end

  // register bank flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      imask_q <= IMASK_RST;
      trig_q <= TRIG_RST;
      ists_q <= 4'h0;
      stat_prev_q <= 4'h0;
      ovr_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      trig_q <= trig_d;
      ists_q <= ists_d;
      stat_prev_q <= stat_now;
      ovr_q <= ovr_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign status_irq = |(ists_q & imask_q);

  // ----------------------------------------
  // transmit framer
  // ----------------------------------------
  hdlcf_tx_e tx_st_q, tx_st_d;
  logic [$clog2(BIT_DIV)-1:0] div_q, div_d;
  logic tx_tick;
  logic [4:0] tbit_q, tbit_d;   // bit index in byte or fcs
  logic [7:0] tsr_q, tsr_d;     // outgoing byte, lsb first
  logic [2:0] tones_q, tones_d; // ones since last zero
  logic [31:0] tcrc_q, tcrc_d;
  logic txd_q, txd_d;
  logic wide;

  assign wide = ctrl_q[CTRL_CRC32];
  assign tx_tick = div_q == '0;

  // bit-time generator and serialiser
  always_comb begin
    div_d = tx_tick ? ($clog2(BIT_DIV))'(BIT_DIV - 1) : div_q - 1'b1;
    tx_st_d = tx_st_q;
    tbit_d = tbit_q;
    tsr_d = tsr_q;
    tones_d = tones_q;
    tcrc_d = tcrc_q;
    txd_d = txd_q;
    txq_pop = 1'b0;
    if (tx_tick) begin
      if (ctrl_q[CTRL_SEND_ONES]) begin
        // ones end any frame at once, no fcs
        tx_st_d = TX_ONES;
        txd_d = 1'b1;
        tones_d = 3'd0; // no stale run carried into the next flag
        tbit_d = 5'd0;
      end else if (tones_q == STUFF_RUN[2:0]) begin
        // last fcs bits may leave five ones pending, stuff before the flag
        txd_d = 1'b0;
        tones_d = 3'd0;
      end else if (tx_st_q == TX_ONES || tx_st_q == TX_FLAG) begin
        // flags sent raw, six ones kept
        txd_d = FLAG_BYTE[tbit_q[2:0]];
        tx_st_d = TX_FLAG;
        tbit_d = tbit_q + 5'd1;
        tones_d = 3'd0;
        if (tbit_q == 5'd7) begin
          tbit_d = 5'd0;
          if (!txq_empty) begin
            txq_pop = 1'b1;
            tsr_d = txq_rdata;
            tcrc_d = wide ? 32'hFFFFFFFF : 32'h0000FFFF;
            tx_st_d = TX_DATA;
          end
        end
      end else if (tx_st_q == TX_DATA) begin
        // bytes sent as-is, fields not interpreted
        txd_d = tsr_q[0];
        tsr_d = {1'b0, tsr_q[7:1]};
        tcrc_d = crc_bit(tcrc_q, tsr_q[0], wide);
        tones_d = tsr_q[0] ? tones_q + 3'd1 : 3'd0;
        tbit_d = tbit_q + 5'd1;
        if (tbit_q == 5'd7) begin
          tbit_d = 5'd0;
          if (!txq_empty) begin
            txq_pop = 1'b1;
            tsr_d = txq_rdata;
          end else begin
            tx_st_d = TX_FCS;
          end
        end
      end else begin
        // complement, highest order first
        txd_d = ~(wide ? tcrc_q[31] : tcrc_q[15]);
        tcrc_d = tcrc_q << 1;
        tones_d = txd_d ? tones_q + 3'd1 : 3'd0;
        tbit_d = tbit_q + 5'd1;
        if (tbit_q == (wide ? 5'd31 : 5'd15)) begin
          tbit_d = 5'd0;
          tx_st_d = TX_FLAG;
        end
      end
    end
  end

  // transmit flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      tx_st_q <= TX_FLAG;
      tbit_q <= 5'd0;
      tsr_q <= 8'h0;
      tones_q <= 3'd0;
      tcrc_q <= 32'h0;
      txd_q <= 1'b1;
    end else begin
      div_q <= div_d;
      tx_st_q <= tx_st_d;
      tbit_q <= tbit_d;
      tsr_q <= tsr_d;
      tones_q <= tones_d;
      tcrc_q <= tcrc_d;
      txd_q <= txd_d;
    end
  end

  assign line_txd = txd_q;

  // ----------------------------------------
  // receive deframer
  // ----------------------------------------
  logic [2:0] rclk_s_q;   // sync pair plus edge copy
  logic [1:0] rxd_s_q;    // sync pair
  logic rx_tick, rbit;
  hdlcf_rx_e rx_st_q, rx_st_d;
  logic [7:0] win_q, win_d;     // raw bits, newest at top
  logic [3:0] rones_q, rones_d; // raw ones run, saturating
  logic [7:0] rsr_q, rsr_d;     // byte being built
  logic [2:0] rbit_q, rbit_d;
  logic [31:0] rcrc_q, rcrc_d;
  logic run_q, run_d;           // inside a run of flags
  logic any_q, any_d;           // bytes since last flag
  logic zerr_q, zerr_d;         // eight zeros seen
  logic is_flag;

  // line inputs through two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rclk_s_q <= 3'h0;
      rxd_s_q <= 2'h3;
    end else begin
      rclk_s_q <= {rclk_s_q[1:0], line_rx_clk};
      rxd_s_q <= {rxd_s_q[0], line_rxd};
    end
  end

  assign rx_tick = rclk_s_q[1] && !rclk_s_q[2];
  assign rbit = rxd_s_q[1];

  // flag, abort and destuff decisions per received bit
  always_comb begin
    win_d = win_q;
    rones_d = rones_q;
    rx_st_d = rx_st_q;
    rsr_d = rsr_q;
    rbit_d = rbit_q;
    rcrc_d = rcrc_q;
    run_d = run_q;
    any_d = any_q;
    zerr_d = zerr_q;
    rxq_push = 1'b0;
    rxq_wdata = '0;
    is_flag = 1'b0;
    if (rx_tick) begin
      win_d = {rbit, win_q[7:1]};
      rones_d = !rbit ? 4'd0 : (rones_q == 4'hF ? rones_q : rones_q + 4'd1);
      // raw window checked bit by bit, so shared zeros work
      is_flag = win_d == FLAG_BYTE;
      if (is_flag) begin
        if (!run_q) begin
          // first flag of a run stored with its check result
          rxq_push = 1'b1;
          rxq_wdata.data = FLAG_BYTE;
          rxq_wdata.flag_detected = 1'b1;
          rxq_wdata.crc_error = zerr_q || (any_q
            && rcrc_q != (wide ? RES32 : RES16));
        end
        run_d = 1'b1; // later flags of the run dropped
        rx_st_d = RX_DATA;
        rcrc_d = wide ? 32'hFFFFFFFF : 32'h0000FFFF;
        any_d = 1'b0;
        zerr_d = 1'b0;
        rbit_d = 3'd0;
      end else if (rones_d == ABORT_RUN) begin
        // seven ones abort; longer runs stay hunting as idle
        if (rx_st_q == RX_DATA) begin
          rxq_push = 1'b1;
          rxq_wdata.data = ABORT_BYTE;
          rxq_wdata.abort_detected = 1'b1;
        end
        rx_st_d = RX_HUNT;
        run_d = 1'b0;
        // aborted frame owes no check result to the next flag
        any_d = 1'b0;
        zerr_d = 1'b0;
      end else if (rx_st_q == RX_DATA) begin
        if (win_d == 8'h00) begin
          zerr_d = 1'b1;
        end
        if (!(rones_q == 4'd5 && !rbit)) begin
          // stuffed zero skipped, others built into bytes
          rsr_d = {rbit, rsr_q[7:1]};
          rbit_d = rbit_q + 3'd1;
          if (rbit_q == 3'd7) begin
            rxq_push = 1'b1;
            rxq_wdata.data = rsr_d;
            rcrc_d = crc_byte(rcrc_q, rsr_d, wide);
            any_d = 1'b1;
            run_d = 1'b0;
          end
        end
      end
    end
  end

  // receive flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q <= RX_HUNT;
      win_q <= 8'h0;
      rones_q <= 4'd0;
      rsr_q <= 8'h0;
      rbit_q <= 3'd0;
      rcrc_q <= 32'h0;
      run_q <= 1'b0;
      any_q <= 1'b0;
      zerr_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      win_q <= win_d;
      rones_q <= rones_d;
      rsr_q <= rsr_d;
      rbit_q <= rbit_d;
      rcrc_q <= rcrc_d;
      run_q <= run_d;
      any_q <= any_d;
      zerr_q <= zerr_d;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TX_STUFF: assert property (
    tx_tick && !ctrl_q[CTRL_SEND_ONES] && (tx_st_q == TX_DATA || tx_st_q == TX_FCS)
    && tones_q == 3'd5 |=> !line_txd && tones_q == 3'd0)
    else $error("no zero after five ones");
  AST_TX_FLAG_RAW: assert property (
    tx_tick && !ctrl_q[CTRL_SEND_ONES] && tx_st_q == TX_FLAG && tbit_q >= 5'd1
    && tbit_q <= 5'd6 |=> line_txd)
    else $error("flag body not all ones");
  AST_TX_ONES: assert property (
    tx_tick && ctrl_q[CTRL_SEND_ONES] |=> line_txd && tx_st_q == TX_ONES)
    else $error("abort ones not sent");
  AST_CRC_PRESET: assert property (
    txq_pop && tx_st_q == TX_FLAG |=> tcrc_q[15:0] == 16'hFFFF)
    else $error("check register not preset");
  AST_OVERRUN: assert property (
    rxq_push && rxq_full |=> ovr_q && rxq_cnt == $past(rxq_cnt) - CW'($past(rx_pop)))
    else $error("overrun not flagged");
  AST_READY: assert property (
    rx_data_ready |-> rxq_cnt >= CW'(trig_q) && rx_queue_not_empty)
    else $error("data ready before trigger level");
  AST_ABORT_ENTRY: assert property (
    rxq_push && rxq_wdata.abort_detected |-> rxq_wdata.data == ABORT_BYTE
    && !rxq_wdata.flag_detected && !rxq_wdata.crc_error ##1 rx_st_q == RX_HUNT)
    else $error("abort entry malformed");
  AST_FLAG_ENTRY: assert property (
    rxq_push && rxq_wdata.flag_detected |-> rxq_wdata.data == FLAG_BYTE
    ##1 run_q)
    else $error("flag entry malformed");
  AST_DESTUFF: assert property (
    rx_tick && rx_st_q == RX_DATA && rones_q == 4'd5 && !rbit && !is_flag
    |=> $stable(rbit_q))
    else $error("stuffed zero kept");
  AST_HALF: assert property (
    $rose(tx_queue_half_full) |-> $past(txq_cnt) == CW'(3))
    else $error("half full at wrong level");

  COV_FLAG: cover property (rxq_push && rxq_wdata.flag_detected);
  COV_ABORT: cover property (rxq_push && rxq_wdata.abort_detected);
  COV_FCS: cover property (tx_st_q == TX_FCS ##1 tx_st_q == TX_FLAG);
  COV_IRQ: cover property ($rose(status_irq));
endmodule

// File: hdlcf_remote.sv
`timescale 1ns/1ns
// ----------------------------------------
// remote station: receive line and bit clock
// ----------------------------------------
module hdlcf_remote (
  input wire logic aclk,
  output logic rxd,
  output logic rx_clk
);
  int ones = 0; // run of data ones, for stuffing
  initial begin
    rxd = 1'b1;
    rx_clk = 1'b0;
  end
  // one bit, held three clocks each side of the rising edge
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (3) @(posedge aclk);
    rx_clk <= 1'b1;
    repeat (3) @(posedge aclk);
    rx_clk <= 1'b0;
  endtask
  // byte lsb first; flags and aborts go unstuffed
  task automatic send(input logic [7:0] b, input logic stuff);
    for (int i = 0; i < 8; i++) begin
      bit_out(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        bit_out(1'b0);
        ones = 0;
      end
    end
    // clock stands still, data line no longer valid
    rxd <= ~b[7];
    @(posedge aclk);
  endtask
endmodule

// File: hdlcf_top_tb_top.sv
`timescale 1ns/1ns
module hdlcf_top_tb_top;
  import hdlcf_pkg::*;
  localparam int BD = 2; // short bit time keeps the run brief
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd, rxc, irq, ok;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] win = 16'h0, t, f, fb;
  int mismatches = 0, compares = 0, run = 0, maxrun = 0, ph = 0;
  hdlcf_top #(.DEPTH(16), .BIT_DIV(BD)) u_hdlcf_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_txd(txd), .line_rxd(rxd), .line_rx_clk(rxc), .status_irq(irq));
  hdlcf_remote u_hdlcf_remote (.aclk(aclk), .rxd(rxd), .rx_clk(rxc));
  initial begin
    forever #50 aclk = ~aclk;
  end
  // mid-bit sampling of the transmit line, longest run of ones
  always @(negedge aclk) begin
    if (aresetn) begin
      ph = (ph + 1) % BD;
      if (ph == 0) begin
        win = {win[14:0], txd};
        run = txd ? run + 1 : 0;
        if (run > maxrun) maxrun = run;
      end
    end
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for a handshake sampled at a rising edge
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 1000; i++) begin
      @(posedge aclk);
      if (s === 1'b1) return;
    end
    mismatches++;
    conclude();
  endtask
  // reference check sequence of one byte: preset ones, msb-first shift, complemented
  function automatic logic [15:0] fcs16(input logic [7:0] b);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < 8; i++) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? POLY16[15:0] : 16'h0000);
    end
    return ~c;
  endfunction
  // each channel released at its own ready; response waited for after both
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_left, w_left;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    for (int i = 0; i < 1000 && (aw_left || w_left); i++) begin
      @(posedge aclk);
      if (aw_left && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_left && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end
    if (aw_left || w_left) begin
      mismatches++;
      conclude();
    end
    wait_hi(bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_hi(arready);
    arvalid <= 1'b0;
    wait_hi(rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // status first, then data, since the data read pops
  task automatic ent(input logic [2:0] es, input logic [7:0] ed);
    rdr(OFS_STATUS);
    chk({29'h0, rd[2:0]}, {29'h0, es});
    rdr(OFS_RXDATA);
    chk({24'h0, rd[7:0]}, {24'h0, ed});
  endtask
  initial begin
    ok = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(OFS_CTRL);
    chk(rd, {29'h0, CTRL_RST});
    rdr(OFS_TRIG);
    chk(rd, {27'h0, TRIG_RST});
    rdr(8'h1C);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(8'h1C, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    repeat (40) @(posedge aclk);
    // idle line: the same flag byte repeated
    for (int r = 0; r < 8; r++) begin
      t = {win[7:0], win[7:0]} >> r;
      if (t[7:0] === FLAG_BYTE && win[15:8] === win[7:0]) ok = 1'b1;
    end
    chk({31'h0, ok}, 32'h1);
    wr(OFS_ISTAT, 32'hF);
    wr(OFS_IMASK, 32'h1);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    u_hdlcf_remote.send(FLAG_BYTE, 1'b0);
    u_hdlcf_remote.send(FLAG_BYTE, 1'b0);
    u_hdlcf_remote.send(8'h3E, 1'b1);
    u_hdlcf_remote.send(ABORT_BYTE, 1'b0);
    repeat (10) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    ent(3'b100, FLAG_BYTE);
    ent(3'b000, 8'h3E);
    ent(3'b001, ABORT_BYTE);
    // one flag entry plus sixteen bytes overflows by one
    u_hdlcf_remote.send(FLAG_BYTE, 1'b0);
    repeat (16) u_hdlcf_remote.send(8'h11, 1'b1);
    rdr(OFS_STATUS);
    chk(rd & 32'hB8, 32'hB8);
    wr(OFS_STATUS, 32'h8);
    rdr(OFS_STATUS);
    chk(rd & 32'h8, 32'h0);
    // empty the queue, then abort, a frame with good check and eight zeros
    repeat (16) rdr(OFS_RXDATA);
    f = fcs16(8'h3E);
    for (int i = 0; i < 8; i++) begin
      fb[i] = f[15 - i];
      fb[8 + i] = f[7 - i];
    end
    u_hdlcf_remote.send(ABORT_BYTE, 1'b0);
    u_hdlcf_remote.send(FLAG_BYTE, 1'b0);
    u_hdlcf_remote.send(8'h3E, 1'b1);
    u_hdlcf_remote.send(fb[7:0], 1'b1);
    u_hdlcf_remote.send(fb[15:8], 1'b1);
    u_hdlcf_remote.send(FLAG_BYTE, 1'b0);
    u_hdlcf_remote.send(8'h00, 1'b1);
    u_hdlcf_remote.send(FLAG_BYTE, 1'b0);
    repeat (10) @(posedge aclk);
    ent(3'b001, ABORT_BYTE);
    ent(3'b100, FLAG_BYTE);
    ent(3'b000, 8'h3E);
    ent(3'b000, fb[7:0]);
    ent(3'b000, fb[15:8]);
    ent(3'b100, FLAG_BYTE);
    ent(3'b000, 8'h00);
    ent(3'b110, FLAG_BYTE);
    maxrun = 0;
    wr(OFS_CTRL, 32'h1);
    repeat (6) wr(OFS_TXDATA, 32'hFF);
    rdr(OFS_STATUS);
    chk({31'h0, rd[8]}, 32'h1);
    repeat (400) @(posedge aclk);
    chk(maxrun, 32'h6);
    wr(OFS_CTRL, 32'h5);
    maxrun = 0;
    repeat (60) @(posedge aclk);
    chk({31'h0, maxrun >= 15}, 32'h1);
    conclude();
  end
endmodule
